// ==== tcc_pkg.sv ====
/*
  Package for the timer control and event register block: register indices, field positions,
  reset values, command and event action codes, and the carrier structs.
  Assumes a 32-bit Avalon-MM slave port with byte addresses of four times the register index.
*/
package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index.
  localparam int unsigned TCC_IDX_W = 6;
  localparam logic [5:0] TCC_IDX_CTRL_A = 6'h00;
  localparam logic [5:0] TCC_IDX_CTRLB_CLR = 6'h04;
  localparam logic [5:0] TCC_IDX_CTRLB_SET = 6'h05;
  localparam logic [5:0] TCC_IDX_CTRL_C = 6'h06;
  localparam logic [5:0] TCC_IDX_DEBUG = 6'h08;
  localparam logic [5:0] TCC_IDX_EVENT_CONTROL = 6'h0a;
  localparam logic [5:0] TCC_IDX_IEN_CLR = 6'h0c;
  localparam logic [5:0] TCC_IDX_IEN_SET = 6'h0d;
  localparam logic [5:0] TCC_IDX_STATUS = 6'h0f;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int unsigned TCC_CA_SWRST = 0;
  localparam int unsigned TCC_CA_ENABLE = 1;
  localparam int unsigned TCC_CA_PRESC_LSB = 8;
  localparam int unsigned TCC_CB_DIR = 0;
  localparam int unsigned TCC_CB_SINGLE_RUN_MODE = 2;
  localparam int unsigned TCC_CB_CMD_LSB = 6;
  localparam int unsigned TCC_CC_INV_LSB = 0;
  localparam int unsigned TCC_CC_CPT_LSB = 4;
  localparam int unsigned TCC_DBG_RUN = 0;
  localparam int unsigned TCC_EV_ACT_LSB = 0;
  localparam int unsigned TCC_EV_POL = 4;
  localparam int unsigned TCC_EV_IEN = 5;
  localparam int unsigned TCC_EV_WRAP_EO = 8;
  localparam int unsigned TCC_EV_MATCH_EO_LSB = 12;
  localparam int unsigned TCC_ST_STOP = 3;
  localparam logic [7:0] TCC_IEN_MASK = 8'h3b;
  localparam logic [7:0] TCC_IEN_RESET = 8'h00;
  localparam logic [9:0] TCC_PRESC_ZERO = 10'h000;

  ////////////////////////////////////////////////////////////////////////////////
  // Codes.
  typedef enum logic [1:0] {
    TCC_CMD_NONE = 2'h0,
    TCC_CMD_RETRIGGER = 2'h1,
    TCC_CMD_STOP = 2'h2,
    TCC_CMD_RSVD = 2'h3
  } tcc_cmd_t;

  typedef enum logic [2:0] {
    TCC_ACT_OFF = 3'h0,
    TCC_ACT_RETRIGGER = 3'h1,
    TCC_ACT_COUNT = 3'h2,
    TCC_ACT_START = 3'h3,
    TCC_ACT_RSVD4 = 3'h4,
    TCC_ACT_PERIOD_WIDTH = 3'h5,
    TCC_ACT_WIDTH_PERIOD = 3'h6,
    TCC_ACT_RSVD7 = 3'h7
  } tcc_act_sel_t;

  typedef enum logic {
    TCC_RUN_STOPPED = 1'b0,
    TCC_RUN_ACTIVE = 1'b1
  } tcc_run_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic count_down;
    logic single_run_mode;
    logic [1:0] capture_channel_enable;
    logic [1:0] output_invert_enable;
    logic run_while_debug_halted;
    logic [7:0] irq_enable;
    logic [2:0] prescale_sel;
  } tcc_cfg_t;

  typedef struct packed {
    logic restart;
    logic count_step;
    logic capture_period;
    logic capture_width;
    logic period_in_slot1;
  } tcc_act_t;

  // Returns the prescaler count mask for a divider selection.
  function automatic logic [9:0] tcc_presc_mask(input logic [2:0] sel);
    logic [9:0] m;
    m = 10'h000;
    case (sel)
      3'h0: m = 10'h000;
      3'h1: m = 10'h001;
      3'h2: m = 10'h003;
      3'h3: m = 10'h007;
      3'h4: m = 10'h00f;
      3'h5: m = 10'h03f;
      3'h6: m = 10'h0ff;
      default: m = 10'h3ff;
    endcase
    return m;
  endfunction : tcc_presc_mask

endpackage : tcc_pkg

// ==== tcc_regs.sv ====
/*
  Control, event and interrupt enable registers of a timer unit with run control,
  prescaler, event input decoding and event output gating.
  Assumes the counting core outside supplies wrap and match pulses and raw waveforms,
  and all inputs are synchronous to core_clk.
*/
// The Avalon-MM register port was decided locally.

// Overview of operation
// - Writing one to single-run bit via clear register turns single-run off.
// - Single-run: counter stops at next wrap; otherwise it keeps counting.
// - Writing one to single-run bit via set register turns single-run on.
// - Writing one to direction via clear register selects counting up.
// - Writing one to direction via set register selects counting down.
// - Set and clear registers share one control state and read back identically.
// - A software command executes on the next prescaled tick.
// - Executed command reads back zero; writing zero does nothing.
// - Command 1 starts or restarts, 2 stops, 3 is reserved.
// - Capture-enable bits select capture per channel, else compare.
// - Inversion bits invert each channel's waveform output.
// - Debug-run bit keeps timer running while the debugger halts the system.
// - Debug-run bit survives a software reset.
// - Match event output per channel when its enable is set.
// - Wrap event output on every wrap when its enable is set.
// - Event input enable gates incoming events.
// - Polarity bit inverts the incoming event before use.
// - Action 0 none, 1 restart, 2 count, 3 start on event.
// - Action 5 period to slot 0 width to slot 1; 6 the reverse.
// - Writing one to interrupt enable clear disables that enable.
// - Interrupt enable set and clear share one set of enable bits.
// - Stopped flag set on disable, stop command, or single-run wrap.
// - Writing one to a command bit via clear cancels a pending command.
module tcc_regs
  import tcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic debug_halt,
  input wire logic wrap_in,
  input wire logic [1:0] match_in,
  input wire logic event_in,
  input wire logic [1:0] wave_raw,
  output tcc_cfg_t cfg,
  output logic counter_run,
  output logic count_enable,
  output tcc_act_t action,
  output logic [1:0] waveform_out,
  output logic wrap_event_out,
  output logic [1:0] match_event_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the access takes effect.
  logic wait_q;
  logic [31:0] rdata_q;
  logic [5:0] idx;
  logic take_wr, wr_lo, wr_hi;
  logic [7:0] wd_lo, wd_hi;
  assign idx = avs_address[7:2];
  assign take_wr = avs_write && !wait_q;
  assign wr_lo = take_wr && avs_byteenable[0];
  assign wr_hi = take_wr && avs_byteenable[1];
  assign wd_lo = avs_writedata[7:0];
  assign wd_hi = avs_writedata[15:8];
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      wait_q <= 1'b1;
    else if ((avs_read || avs_write) && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.
  logic enable_q, dir_q, single_run_mode_q, run_while_debug_halted_q, evpol_q, evien_q, wrap_eo_q, swrst, tick_q;
  logic [2:0] presc_sel_q, event_action_select_q;
  logic [1:0] cmd_q, cpt_q, inv_q, match_eo_q;
  logic [7:0] ien_q;
  tcc_run_t run_q;
  assign swrst = wr_lo && idx == TCC_IDX_CTRL_A && wd_lo[TCC_CA_SWRST];
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || swrst)
    begin
      enable_q <= 1'b0;
      presc_sel_q <= 3'h0;
    end
    else if (idx == TCC_IDX_CTRL_A)
    begin
      if (wr_lo)
        enable_q <= wd_lo[TCC_CA_ENABLE];
      if (wr_hi)
        presc_sel_q <= wd_hi[TCC_CA_PRESC_LSB-8 +: 3];
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || swrst)
    begin
      dir_q <= 1'b0;
      single_run_mode_q <= 1'b0;
    end
    else if (wr_lo && idx == TCC_IDX_CTRLB_CLR)
    begin
      if (wd_lo[TCC_CB_DIR])
        dir_q <= 1'b0;
      if (wd_lo[TCC_CB_SINGLE_RUN_MODE])
        single_run_mode_q <= 1'b0;
    end
    else if (wr_lo && idx == TCC_IDX_CTRLB_SET)
    begin
      if (wd_lo[TCC_CB_DIR])
        dir_q <= 1'b1;
      if (wd_lo[TCC_CB_SINGLE_RUN_MODE])
        single_run_mode_q <= 1'b1;
    end
  end
  // A new command set in the tick cycle wins over the hardware clear.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || swrst)
      cmd_q <= TCC_CMD_NONE;
    else if (wr_lo && idx == TCC_IDX_CTRLB_SET && wd_lo[TCC_CB_CMD_LSB +: 2] != TCC_CMD_NONE)
      cmd_q <= wd_lo[TCC_CB_CMD_LSB +: 2];
    else if (wr_lo && idx == TCC_IDX_CTRLB_CLR && wd_lo[TCC_CB_CMD_LSB +: 2] != TCC_CMD_NONE)
      cmd_q <= TCC_CMD_NONE;
    else if (tick_q)
      cmd_q <= TCC_CMD_NONE;
  end
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || swrst)
    begin
      cpt_q <= 2'h0;
      inv_q <= 2'h0;
      event_action_select_q <= TCC_ACT_OFF;
      evpol_q <= 1'b0;
      evien_q <= 1'b0;
      wrap_eo_q <= 1'b0;
      match_eo_q <= 2'h0;
    end
    else
    begin
      if (wr_lo && idx == TCC_IDX_CTRL_C)
      begin
        cpt_q <= wd_lo[TCC_CC_CPT_LSB +: 2];
        inv_q <= wd_lo[TCC_CC_INV_LSB +: 2];
      end
      if (wr_lo && idx == TCC_IDX_EVENT_CONTROL)
      begin
        event_action_select_q <= wd_lo[TCC_EV_ACT_LSB +: 3];
        evpol_q <= wd_lo[TCC_EV_POL];
        evien_q <= wd_lo[TCC_EV_IEN];
      end
      if (wr_hi && idx == TCC_IDX_EVENT_CONTROL)
      begin
        wrap_eo_q <= wd_hi[TCC_EV_WRAP_EO-8];
        match_eo_q <= wd_hi[TCC_EV_MATCH_EO_LSB-8 +: 2];
      end
    end
  end
  // Only the power-on reset touches the debug-run bit.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      run_while_debug_halted_q <= 1'b0;
    else if (wr_lo && idx == TCC_IDX_DEBUG)
      run_while_debug_halted_q <= wd_lo[TCC_DBG_RUN];
  end
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || swrst)
      ien_q <= TCC_IEN_RESET;
    else if (wr_lo && idx == TCC_IDX_IEN_CLR)
      ien_q <= ien_q & ~(wd_lo & TCC_IEN_MASK);
    else if (wr_lo && idx == TCC_IDX_IEN_SET)
      ien_q <= ien_q | (wd_lo & TCC_IEN_MASK);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Read data, prepared in the wait cycle.
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0000_0000;
    case (idx)
      TCC_IDX_CTRL_A:
      begin
        rmux[TCC_CA_ENABLE] = enable_q;
        rmux[TCC_CA_PRESC_LSB +: 3] = presc_sel_q;
      end
      TCC_IDX_CTRLB_CLR, TCC_IDX_CTRLB_SET:
      begin
        rmux[TCC_CB_CMD_LSB +: 2] = cmd_q;
        rmux[TCC_CB_SINGLE_RUN_MODE] = single_run_mode_q;
        rmux[TCC_CB_DIR] = dir_q;
      end
      TCC_IDX_CTRL_C:
      begin
        rmux[TCC_CC_CPT_LSB +: 2] = cpt_q;
        rmux[TCC_CC_INV_LSB +: 2] = inv_q;
      end
      TCC_IDX_DEBUG: rmux[TCC_DBG_RUN] = run_while_debug_halted_q;
      TCC_IDX_EVENT_CONTROL:
      begin
        rmux[TCC_EV_ACT_LSB +: 3] = event_action_select_q;
        rmux[TCC_EV_POL] = evpol_q;
        rmux[TCC_EV_IEN] = evien_q;
        rmux[TCC_EV_WRAP_EO] = wrap_eo_q;
        rmux[TCC_EV_MATCH_EO_LSB +: 2] = match_eo_q;
      end
      TCC_IDX_IEN_CLR, TCC_IDX_IEN_SET: rmux[7:0] = ien_q;
      TCC_IDX_STATUS: rmux[TCC_ST_STOP] = (run_q == TCC_RUN_STOPPED);
      default: rmux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && wait_q)
      rdata_q <= rmux;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler; it halts with the system unless debug-run is set.
  logic [9:0] presc_q, pmask;
  logic halted;
  assign halted = debug_halt && !run_while_debug_halted_q;
  assign pmask = tcc_presc_mask(presc_sel_q);
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || !enable_q || halted)
    begin
      presc_q <= TCC_PRESC_ZERO;
      tick_q <= 1'b0;
    end
    else
    begin
      presc_q <= ((presc_q & pmask) == pmask) ? TCC_PRESC_ZERO : presc_q + 10'h001;
      tick_q <= (presc_q & pmask) == pmask;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Event input decode.
  logic ev_prev_q, ev_lvl, ev_rise, ev_fall;
  assign ev_lvl = (event_in ^ evpol_q) && evien_q;
  assign ev_rise = ev_lvl && !ev_prev_q;
  assign ev_fall = !ev_lvl && ev_prev_q;
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      ev_prev_q <= 1'b0;
    else
      ev_prev_q <= ev_lvl;
  end
  logic ev_restart, ev_start;
  always_comb
  begin
    ev_restart = 1'b0;
    ev_start = 1'b0;
    case (tcc_act_sel_t'(event_action_select_q))
      TCC_ACT_RETRIGGER: ev_restart = ev_rise;
      TCC_ACT_START: ev_start = ev_rise && run_q == TCC_RUN_STOPPED;
      TCC_ACT_PERIOD_WIDTH, TCC_ACT_WIDTH_PERIOD: ev_restart = ev_rise;
      default: ev_restart = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || !enable_q)
      action <= '0;
    else
    begin
      action.restart <= ev_restart || ev_start || (tick_q && cmd_q == TCC_CMD_RETRIGGER);
      action.count_step <= ev_rise && event_action_select_q == TCC_ACT_COUNT;
      action.capture_period <= ev_rise && (event_action_select_q == TCC_ACT_PERIOD_WIDTH || event_action_select_q == TCC_ACT_WIDTH_PERIOD);
      action.capture_width <= ev_fall && (event_action_select_q == TCC_ACT_PERIOD_WIDTH || event_action_select_q == TCC_ACT_WIDTH_PERIOD);
      action.period_in_slot1 <= event_action_select_q == TCC_ACT_WIDTH_PERIOD;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Run control; stop causes win over start causes in the same cycle.
  logic stop_now, start_now;
  assign stop_now = (tick_q && cmd_q == TCC_CMD_STOP) || (wrap_in && single_run_mode_q);
  assign start_now = (tick_q && cmd_q == TCC_CMD_RETRIGGER) || ev_restart || ev_start;
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || !enable_q)
      run_q <= TCC_RUN_STOPPED;
    else if (stop_now)
      run_q <= TCC_RUN_STOPPED;
    else if (start_now)
      run_q <= TCC_RUN_ACTIVE;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      cfg <= '0;
      counter_run <= 1'b0;
      count_enable <= 1'b0;
      waveform_out <= 2'h0;
      wrap_event_out <= 1'b0;
      match_event_out <= 2'h0;
    end
    else
    begin
      cfg.count_down <= dir_q;
      cfg.single_run_mode <= single_run_mode_q;
      cfg.capture_channel_enable <= cpt_q;
      cfg.output_invert_enable <= inv_q;
      cfg.run_while_debug_halted <= run_while_debug_halted_q;
      cfg.irq_enable <= ien_q;
      cfg.prescale_sel <= presc_sel_q;
      counter_run <= run_q == TCC_RUN_ACTIVE;
      count_enable <= run_q == TCC_RUN_ACTIVE && tick_q && !halted;
      waveform_out <= wave_raw ^ inv_q;
      wrap_event_out <= wrap_in && wrap_eo_q;
      match_event_out <= match_in & match_eo_q;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_SINGLE_RUN_MODE_CLR: assert property (wr_lo && idx == TCC_IDX_CTRLB_CLR && wd_lo[TCC_CB_SINGLE_RUN_MODE] |=> !single_run_mode_q)
    else $error("single-run not cleared");
  AST_SINGLE_RUN_MODE_SET: assert property (wr_lo && idx == TCC_IDX_CTRLB_SET && wd_lo[TCC_CB_SINGLE_RUN_MODE] && !swrst |=> single_run_mode_q)
    else $error("single-run not set");
  AST_DIR_CLR: assert property (wr_lo && idx == TCC_IDX_CTRLB_CLR && wd_lo[TCC_CB_DIR] |=> ##1 !cfg.count_down)
    else $error("direction not cleared");
  AST_DIR_SET: assert property (wr_lo && idx == TCC_IDX_CTRLB_SET && wd_lo[TCC_CB_DIR] |=> ##1 cfg.count_down)
    else $error("direction not set");
  AST_CMD_DONE: assert property (tick_q && cmd_q != TCC_CMD_NONE && !(wr_lo && idx == TCC_IDX_CTRLB_SET) |=> cmd_q == TCC_CMD_NONE)
    else $error("command not cleared after tick");
  AST_SINGLE_RUN_MODE_STOP: assert property (wrap_in && single_run_mode_q |=> ##1 !counter_run)
    else $error("single-run did not stop");
  AST_WRAP_EVT: assert property (##1 wrap_event_out == $past(wrap_in && wrap_eo_q))
    else $error("wrap event gating wrong");
  AST_INVERT: assert property (##1 waveform_out == ($past(wave_raw) ^ $past(inv_q)))
    else $error("waveform inversion wrong");
  AST_EVT_OFF: assert property (!evien_q |=> !action.count_step && !action.capture_period)
    else $error("event accepted while disabled");
  AST_DBG_HALT: assert property (debug_halt && !run_while_debug_halted_q |=> !count_enable)
    else $error("counting while halted");
  AST_STOP_DISABLE: assert property (!enable_q |=> run_q == TCC_RUN_STOPPED)
    else $error("not stopped while disabled");

  COV_CMD_START: cover property (tick_q && cmd_q == TCC_CMD_RETRIGGER ##1 run_q == TCC_RUN_ACTIVE);
  COV_SINGLE_RUN_MODE: cover property (run_q == TCC_RUN_ACTIVE && wrap_in && single_run_mode_q);
  COV_CAPTURE: cover property (action.capture_period ##[1:50] action.capture_width);

endmodule : tcc_regs

// ==== tcc_regs_bench.sv ====
/*
  Self-checking bench for tcc_regs: register access over Avalon-MM, commands, events and outputs.
  Assumes tcc_pkg and tcc_regs are compiled first and that the assertions live in the design.
*/
module tcc_regs_bench
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals.
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic debug_halt = 1'b0;
  logic wrap_in = 1'b0;
  logic [1:0] match_in = 2'h0;
  logic event_in = 1'b0;
  logic [1:0] wave_raw = 2'h0;
  tcc_cfg_t cfg;
  logic counter_run;
  logic count_enable;
  tcc_act_t action;
  logic [1:0] waveform_out;
  logic wrap_event_out;
  logic [1:0] match_event_out;
  int miscompares = 0;
  int compares = 0;
  int ticks = 0;
  logic [7:0] seen = 8'h00;
  logic [31:0] rdata = 32'h0;
  logic [5:0] rv_idx [9] = '{6'h04, 6'h05, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h0d, 6'h0f, 6'h3f};
  logic [7:0] rv_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
  logic [3:0] act_exp [8] = '{4'h0, 4'h8, 4'h4, 4'h8, 4'h0, 4'hb, 4'hb, 4'h0};

  always #12.5 core_clk = ~core_clk;

  tcc_regs DUT (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .debug_halt(debug_halt),
    .wrap_in(wrap_in),
    .match_in(match_in),
    .event_in(event_in),
    .wave_raw(wave_raw),
    .cfg(cfg),
    .counter_run(counter_run),
    .count_enable(count_enable),
    .action(action),
    .waveform_out(waveform_out),
    .wrap_event_out(wrap_event_out),
    .match_event_out(match_event_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks.
  task automatic test_done();
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd, input logic [3:0] be);
    int n;
    @(posedge core_clk);
    avs_address <= {idx, 2'h0};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      $display("Error at %0t: got %h expected %h", $time, avs_waitrequest, 1'b0);
      miscompares++;
      test_done();
    end
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 4'h3);
  endtask : wr

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, 4'h3);
    chk(rdata, exp);
  endtask : rd_chk

  // Writes a register with the unit disabled, then enables it again, which leaves it stopped.
  task automatic cfg_wr(input logic [5:0] idx, input logic [31:0] d);
    wr(TCC_IDX_CTRL_A, 32'h0);
    wr(idx, d);
    wr(TCC_IDX_CTRL_A, 32'h2);
  endtask : cfg_wr

  task automatic collect(input int n, input bit fresh);
    if (fresh)
    begin
      seen = 8'h00;
      ticks = 0;
    end
    repeat (n)
    begin
      @(negedge core_clk);
      seen |= {action.restart, action.count_step, action.capture_period, action.capture_width,
               wrap_event_out, match_event_out, count_enable};
      ticks = ticks + int'(count_enable);
    end
  endtask : collect

  task automatic set_in(input logic w, input logic [1:0] m, input logic e);
    @(posedge core_clk);
    wrap_in <= w;
    match_in <= m;
    event_in <= e;
  endtask : set_in

  task automatic stim(input logic w, input logic [1:0] m, input logic e, input int n);
    set_in(w, m, e);
    collect(1, 1'b1);
    set_in(1'b0, 2'h0, 1'b0);
    collect(n, 1'b0);
  endtask : stim

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk(rv_idx[i], 32'(rv_val[i]));
    wr(6'h3e, 32'hff);
    rd_chk(6'h3e, 32'h0);
    $display("Test 1 done");
    wr(TCC_IDX_CTRLB_SET, 32'h05);
    rd_chk(TCC_IDX_CTRLB_CLR, 32'h05);
    chk(32'({cfg.count_down, cfg.single_run_mode}), 32'h3);
    wr(TCC_IDX_CTRLB_CLR, 32'h00);
    rd_chk(TCC_IDX_CTRLB_SET, 32'h05);
    wr(TCC_IDX_CTRLB_CLR, 32'h04);
    rd_chk(TCC_IDX_CTRLB_SET, 32'h01);
    wr(TCC_IDX_CTRLB_SET, 32'h00);
    rd_chk(TCC_IDX_CTRLB_CLR, 32'h01);
    wr(TCC_IDX_CTRLB_CLR, 32'h01);
    rd_chk(TCC_IDX_CTRLB_SET, 32'h00);
    chk(32'(cfg.count_down), 32'h0);
    $display("Test 2 done");
    wr(TCC_IDX_CTRLB_SET, 32'h40);
    rd_chk(TCC_IDX_CTRLB_SET, 32'h40);
    wr(TCC_IDX_CTRLB_CLR, 32'h80);
    rd_chk(TCC_IDX_CTRLB_SET, 32'h00);
    wr(TCC_IDX_CTRL_A, 32'h302);
    wr(TCC_IDX_CTRLB_SET, 32'h40);
    collect(12, 1'b1);
    chk(32'(counter_run), 32'h1);
    chk(32'(cfg.prescale_sel), 32'h3);
    rd_chk(TCC_IDX_CTRLB_SET, 32'h00);
    rd_chk(TCC_IDX_STATUS, 32'h00);
    wr(TCC_IDX_CTRLB_SET, 32'hc0);
    collect(12, 1'b1);
    chk(32'(counter_run), 32'h1);
    rd_chk(TCC_IDX_CTRLB_CLR, 32'h00);
    wr(TCC_IDX_CTRLB_SET, 32'h80);
    collect(12, 1'b1);
    chk(32'(counter_run), 32'h0);
    rd_chk(TCC_IDX_STATUS, 32'h08);
    $display("Test 3 done");
    cfg_wr(TCC_IDX_EVENT_CONTROL, 32'h1100);
    wr(TCC_IDX_CTRLB_SET, 32'h44);
    collect(4, 1'b1);
    chk(32'(counter_run), 32'h1);
    stim(1'b1, 2'h3, 1'b0, 4);
    chk(32'(seen[3:1]), 32'h5);
    chk(32'(counter_run), 32'h0);
    rd_chk(TCC_IDX_STATUS, 32'h08);
    wr(TCC_IDX_CTRLB_CLR, 32'h04);
    wr(TCC_IDX_CTRLB_SET, 32'h40);
    stim(1'b1, 2'h0, 1'b0, 4);
    chk(32'(counter_run), 32'h1);
    cfg_wr(TCC_IDX_EVENT_CONTROL, 32'h2000);
    stim(1'b1, 2'h3, 1'b0, 4);
    chk(32'(seen[3:1]), 32'h2);
    $display("Test 4 done");
    for (int a = 0; a < 8; a++)
    begin
      cfg_wr(TCC_IDX_EVENT_CONTROL, 32'h20 | 32'(a));
      stim(1'b0, 2'h0, 1'b1, 6);
      chk(32'(seen[7:4]), 32'(act_exp[a]));
      chk(32'(action.period_in_slot1), 32'(a == 6));
    end
    cfg_wr(TCC_IDX_EVENT_CONTROL, 32'h02);
    stim(1'b0, 2'h0, 1'b1, 6);
    chk(32'(seen[6]), 32'h0);
    cfg_wr(TCC_IDX_EVENT_CONTROL, 32'h32);
    set_in(1'b0, 2'h0, 1'b1);
    collect(6, 1'b1);
    chk(32'(seen[6]), 32'h0);
    set_in(1'b0, 2'h0, 1'b0);
    collect(6, 1'b1);
    chk(32'(seen[6]), 32'h1);
    $display("Test 5 done");
    wr(TCC_IDX_CTRL_C, 32'h31);
    rd_chk(TCC_IDX_CTRL_C, 32'h31);
    bus(1'b1, TCC_IDX_CTRL_C, 32'hff, 4'h2);
    rd_chk(TCC_IDX_CTRL_C, 32'h31);
    chk(32'({cfg.capture_channel_enable, cfg.output_invert_enable}), 32'hd);
    @(posedge core_clk);
    wave_raw <= 2'h3;
    collect(3, 1'b1);
    chk(32'(waveform_out), 32'h2);
    wr(TCC_IDX_CTRL_C, 32'h02);
    collect(3, 1'b1);
    chk(32'(waveform_out), 32'h1);
    $display("Test 6 done");
    wr(TCC_IDX_CTRL_A, 32'h2);
    wr(TCC_IDX_CTRLB_SET, 32'h40);
    @(posedge core_clk);
    debug_halt <= 1'b1;
    collect(4, 1'b1);
    collect(8, 1'b1);
    chk(32'(ticks), 32'h0);
    wr(TCC_IDX_CTRL_A, 32'h0);
    wr(TCC_IDX_DEBUG, 32'h1);
    wr(TCC_IDX_CTRL_A, 32'h2);
    wr(TCC_IDX_CTRLB_SET, 32'h40);
    collect(12, 1'b1);
    chk(32'(ticks != 0), 32'h1);
    @(posedge core_clk);
    debug_halt <= 1'b0;
    wr(TCC_IDX_CTRL_A, 32'h1);
    rd_chk(TCC_IDX_DEBUG, 32'h1);
    rd_chk(TCC_IDX_CTRL_C, 32'h0);
    chk(32'(cfg.run_while_debug_halted), 32'h1);
    $display("Test 7 done");
    wr(TCC_IDX_IEN_SET, 32'hff);
    rd_chk(TCC_IDX_IEN_CLR, 32'h3b);
    wr(TCC_IDX_IEN_CLR, 32'h10);
    rd_chk(TCC_IDX_IEN_SET, 32'h2b);
    wr(TCC_IDX_IEN_CLR, 32'h00);
    rd_chk(TCC_IDX_IEN_CLR, 32'h2b);
    chk(32'(cfg.irq_enable), 32'h2b);
    $display("Test 8 done");
    test_done();
  end

endmodule : tcc_regs_bench
